/* File: hw/frame_timer_pkg.sv */
// Package of register codes, field layouts, reset values and timing for the frame interval timer.
// Assumes a single 100 MHz core clock and the command-code register port of the host controller.
package frame_timer_pkg;
    localparam logic [7:0] CMD_INTERVAL_RD = 8'h0D;
    localparam logic [7:0] CMD_INTERVAL_WR = 8'h8D;
    localparam logic [7:0] CMD_REMAINING_RD = 8'h0E;
    localparam logic [7:0] CMD_FRAME_NUM_RD = 8'h0F;
    // Set in every write code; such codes never answer
    localparam int CMD_WRITE_BIT = 7;
    localparam int FL_W = 14;
    localparam int LP_W = 15;
    localparam int FN_W = 16;
    localparam int FL_LSB = 0;
    localparam int LP_LSB = 16;
    localparam int TOGGLE_BIT = 31;
    localparam logic [FL_W-1:0] FL_DEFAULT = 14'h2EDF;
    localparam logic [FL_W-1:0] FL_ZERO = 14'h0000;
    localparam logic [LP_W-1:0] LP_DEFAULT = 15'h0000;
    localparam logic [FN_W-1:0] FN_ZERO = 16'h0000;
    localparam logic [FN_W-1:0] FN_ONE = 16'h0001;
    localparam logic [FL_W-1:0] FL_ONE = 14'h0001;
    localparam logic [LP_W-1:0] LP_ZERO = 15'h0000;
    localparam logic [LP_W-1:0] LP_ONE = 15'h0001;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // Full-speed bit rate in bit/s and core clock in Hz
    localparam longint CORE_HZ = 100_000_000;
    localparam longint BIT_HZ = 12_000_000;
    // Fractional accumulator: add BIT_HZ each clock, tick when CORE_HZ passed
    localparam int ACC_W = 28;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BIT_HZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CORE_HZ);
    localparam logic [ACC_W-1:0] ACC_ZERO = 28'h000_0000;
    typedef enum logic [1:0] {
        ST_HALT = 2'b01,
        ST_RUN = 2'b10
    } bus_state_e;
endpackage : frame_timer_pkg

/* File: hw/bit_tick_gen.sv */
// Bit-time tick generator: one pulse per 12 Mbit/s bit period, averaged exactly.
// Assumes the 100 MHz core clock; ticks jitter by one clock, averaging to the bit rate.
module bit_tick_gen (
    input wire logic core_clk_in, // Core clock
    input wire logic rst_b_in, // Sync reset, active low
    input wire logic run_in, // Count while high
    output logic tick_out // One-cycle bit-time pulse
);
    import frame_timer_pkg::*;
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic [ACC_W-1:0] sum;
    always_comb begin
        sum = acc_r + ACC_STEP;
        tick_out = run_in && (sum >= ACC_WRAP);
        if (!run_in) begin
            acc_nxt = ACC_ZERO;
        end else if (sum >= ACC_WRAP) begin
            acc_nxt = sum - ACC_WRAP;
        end else begin
            acc_nxt = sum;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            acc_r <= ACC_ZERO;
        end else begin
            acc_r <= acc_nxt;
        end
    end
endmodule : bit_tick_gen

/* File: hw/usb_frame_interval_timer.sv */
// Frame interval timer: frame length register, bits-remaining down counter, frame number, packet budget.
// Assumes commands arrive as one-cycle strobes with a code; read data is registered one cycle later.
module usb_frame_interval_timer (
    input wire logic core_clk_in, // 100 MHz core clock
    input wire logic rst_b_in, // Sync reset, active low
    input wire logic soft_reset_in, // controller_soft_reset pulse
    input wire logic bus_active_state_in, // High while bus is operational
    input wire logic cmd_valid_in, // Command strobe
    input wire logic [7:0] cmd_code_in, // Command code
    input wire logic [31:0] cmd_wdata_in, // Write data
    input wire logic packet_bits_used_in, // One data bit moved this cycle
    output logic [31:0] rdata_out, // Read data, registered
    output logic rvalid_out, // Read data valid pulse
    output logic sof_out, // Start-of-frame pulse
    output logic [frame_timer_pkg::FN_W-1:0] frame_number_out, // frame_sequence_count
    output logic packet_fits_out // Budget left in largest-packet counter
);
    import frame_timer_pkg::*;
    bus_state_e state_r, state_nxt;
    logic [FL_W-1:0] frame_len_r, frame_len_nxt;
    logic [LP_W-1:0] lp_bits_r, lp_bits_nxt;
    logic int_toggle_r, int_toggle_nxt;
    logic [FL_W-1:0] remain_r, remain_nxt;
    logic rem_toggle_r, rem_toggle_nxt;
    logic [FN_W-1:0] fn_r, fn_nxt;
    logic [LP_W-1:0] lp_cnt_r, lp_cnt_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic sof_r, sof_nxt;
    logic tick;
    logic wr_int;
    logic enter_run;
    logic reload;

    bit_tick_gen u_tick (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .run_in(state_r == ST_RUN),
        .tick_out(tick)
    );

    assign wr_int = cmd_valid_in && (cmd_code_in == CMD_INTERVAL_WR);
    assign enter_run = (state_r == ST_HALT) && bus_active_state_in;
    assign reload = (state_r == ST_RUN) && tick && (remain_r == FL_ZERO);

    always_comb begin
        frame_len_nxt = frame_len_r;
        lp_bits_nxt = lp_bits_r;
        int_toggle_nxt = int_toggle_r;
        if (soft_reset_in) begin
            // Whole register to defaults; saving the length is software's job
            frame_len_nxt = FL_DEFAULT;
            lp_bits_nxt = LP_DEFAULT;
            int_toggle_nxt = 1'b0;
        end else if (wr_int) begin
            frame_len_nxt = cmd_wdata_in[FL_LSB +: FL_W];
            lp_bits_nxt = cmd_wdata_in[LP_LSB +: LP_W];
            int_toggle_nxt = cmd_wdata_in[TOGGLE_BIT];
        end
    end

    always_comb begin
        state_nxt = state_r;
        remain_nxt = remain_r;
        rem_toggle_nxt = rem_toggle_r;
        fn_nxt = fn_r;
        lp_cnt_nxt = lp_cnt_r;
        sof_nxt = 1'b0;
        case (state_r)
            ST_HALT: begin
                if (bus_active_state_in) begin
                    state_nxt = ST_RUN;
                    remain_nxt = frame_len_r;
                    fn_nxt = fn_r + FN_ONE;
                    lp_cnt_nxt = lp_bits_r;
                    sof_nxt = 1'b1;
                end
            end
            ST_RUN: begin
                if (!bus_active_state_in) begin
                    state_nxt = ST_HALT;
                end else if (reload) begin
                    remain_nxt = frame_len_r;
                    rem_toggle_nxt = int_toggle_r;
                    fn_nxt = fn_r + FN_ONE;
                    lp_cnt_nxt = lp_bits_r;
                    sof_nxt = 1'b1;
                end else begin
                    if (tick) begin
                        remain_nxt = remain_r - FL_ONE;
                    end
                    // Budget shrinks per data bit; stops at zero
                    if (packet_bits_used_in && lp_cnt_r != LP_ZERO) begin
                        lp_cnt_nxt = lp_cnt_r - LP_ONE;
                    end
                end
            end
            default: begin
                state_nxt = ST_HALT;
            end
        endcase
        if (soft_reset_in) begin
            state_nxt = ST_HALT;
            remain_nxt = FL_ZERO;
            rem_toggle_nxt = 1'b0;
            fn_nxt = FN_ZERO;
            lp_cnt_nxt = LP_ZERO;
        end
    end

    always_comb begin
        rdata_nxt = WORD_ZERO;
        rvalid_nxt = cmd_valid_in && !cmd_code_in[CMD_WRITE_BIT];
        if (cmd_valid_in) begin
            case (cmd_code_in)
                CMD_INTERVAL_RD: begin
                    rdata_nxt[FL_LSB +: FL_W] = frame_len_r;
                    rdata_nxt[LP_LSB +: LP_W] = lp_bits_r;
                    rdata_nxt[TOGGLE_BIT] = int_toggle_r;
                end
                CMD_REMAINING_RD: begin
                    rdata_nxt[FL_LSB +: FL_W] = remain_r;
                    rdata_nxt[TOGGLE_BIT] = rem_toggle_r;
                end
                CMD_FRAME_NUM_RD: begin
                    rdata_nxt[FN_W-1:0] = fn_r;
                end
                default: begin
                    rdata_nxt = WORD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            state_r <= ST_HALT;
            frame_len_r <= FL_DEFAULT;
            lp_bits_r <= LP_DEFAULT;
            int_toggle_r <= 1'b0;
            remain_r <= FL_ZERO;
            rem_toggle_r <= 1'b0;
            fn_r <= FN_ZERO;
            lp_cnt_r <= LP_ZERO;
            rdata_r <= WORD_ZERO;
            rvalid_r <= 1'b0;
            sof_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            frame_len_r <= frame_len_nxt;
            lp_bits_r <= lp_bits_nxt;
            int_toggle_r <= int_toggle_nxt;
            remain_r <= remain_nxt;
            rem_toggle_r <= rem_toggle_nxt;
            fn_r <= fn_nxt;
            lp_cnt_r <= lp_cnt_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            sof_r <= sof_nxt;
        end
    end

    assign rdata_out = rdata_r;
    assign rvalid_out = rvalid_r;
    assign sof_out = sof_r;
    assign frame_number_out = fn_r;
    assign packet_fits_out = (lp_cnt_r != LP_ZERO);

    a_reset_len: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        soft_reset_in |=> frame_len_r == FL_DEFAULT)
        else $error("length not defaulted");
    a_soft_clear: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        soft_reset_in |=> state_r == ST_HALT && fn_r == FN_ZERO && !int_toggle_r && lp_bits_r == LP_DEFAULT)
        else $error("soft reset left state behind");
    a_write_len: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        wr_int && !soft_reset_in |=> frame_len_r == $past(cmd_wdata_in[FL_LSB +: FL_W]))
        else $error("length write lost");
    a_count_down: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        state_r == ST_RUN && bus_active_state_in && tick && remain_r != FL_ZERO && !soft_reset_in
        |=> remain_r == $past(remain_r) - FL_ONE)
        else $error("no decrement");
    a_hold_idle: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        state_r == ST_RUN && bus_active_state_in && !tick && !soft_reset_in
        |=> $stable(remain_r))
        else $error("count moved without tick");
    a_zero_reload: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        reload && bus_active_state_in && !soft_reset_in
        |=> remain_r == $past(frame_len_r) && sof_r)
        else $error("no reload");
    a_toggle_copy: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        reload && bus_active_state_in && !soft_reset_in
        |=> rem_toggle_r == $past(int_toggle_r))
        else $error("toggle not copied");
    a_enter_load: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        enter_run && !soft_reset_in
        |=> state_r == ST_RUN && remain_r == $past(frame_len_r))
        else $error("entry load");
    a_fn_step: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        sof_nxt && !soft_reset_in |=> fn_r == $past(fn_r) + FN_ONE)
        else $error("frame number step");
    a_lp_load: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        sof_nxt && !soft_reset_in |=> lp_cnt_r == $past(lp_bits_r))
        else $error("packet budget load");
    a_budget_floor: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        lp_cnt_r == LP_ZERO && !sof_nxt |=> lp_cnt_r == LP_ZERO)
        else $error("packet budget wrapped");
    a_rem_read: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        cmd_valid_in && cmd_code_in == CMD_REMAINING_RD
        |=> rvalid_out && rdata_out[TOGGLE_BIT-1:FL_W] == '0 && rdata_out[FL_LSB +: FL_W] == $past(remain_r))
        else $error("remaining read");
    a_write_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        wr_int |=> !rvalid_out && rdata_out == WORD_ZERO)
        else $error("write answered");
    a_tick_rate: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        tick |=> !tick ##1 !tick ##1 !tick ##1 !tick
        ##1 !tick ##1 !tick ##1 !tick)
        else $error("tick too fast");
endmodule : usb_frame_interval_timer

/* File: testbench/tb.sv */
// Self-checking bench for the frame interval timer: register codes, frame timing, toggle, packet budget.
// Assumes the timer's read answer one cycle after the command and a bit tick every 8 or 9 core clocks.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import frame_timer_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic soft_reset_in = 1'b0;
    logic bus_active_state_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    logic [7:0] cmd_code_in = 8'h00;
    logic [31:0] cmd_wdata_in = 32'h0000_0000;
    logic packet_bits_used_in = 1'b0;
    logic [31:0] rdata_out;
    logic rvalid_out;
    logic sof_out;
    logic [FN_W-1:0] frame_number_out;
    logic packet_fits_out;
    int failures = 0;
    int total_checks = 0;
    int cycle_count = 0;
    int gap;
    always #5 core_clk_in = ~core_clk_in;
    usb_frame_interval_timer DUT (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .soft_reset_in(soft_reset_in),
        .bus_active_state_in(bus_active_state_in), .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
        .cmd_wdata_in(cmd_wdata_in), .packet_bits_used_in(packet_bits_used_in), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out), .sof_out(sof_out), .frame_number_out(frame_number_out),
        .packet_fits_out(packet_fits_out));
    task automatic end_sim();
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // Hang guard: whole run needs under a thousand cycles
    always @(posedge core_clk_in) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 20000) begin
            failures = failures + 1;
            $display("MISMATCH at %0t: run did not finish", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic write_reg(input logic [7:0] code, input logic [31:0] data);
        @(posedge core_clk_in);
        cmd_valid_in <= 1'b1;
        cmd_code_in <= code;
        cmd_wdata_in <= data;
        @(posedge core_clk_in);
        cmd_valid_in <= 1'b0;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] code, output logic [31:0] data);
        write_reg(code, 32'h0000_0000);
        #1;
        chk({31'h0000_0000, rvalid_out}, 32'h0000_0001, "read answer valid");
        data = rdata_out;
    endtask : read_reg
    // Returns clocks waited until the next start-of-frame pulse
    task automatic wait_sof(output int n);
        n = 0;
        do begin
            @(posedge core_clk_in);
            #1;
            n = n + 1;
        end while (sof_out !== 1'b1 && n < 400);
        chk({31'h0000_0000, sof_out}, 32'h0000_0001, "start of frame seen");
    endtask : wait_sof
    task automatic test_defaults();
        logic [31:0] d;
        read_reg(CMD_INTERVAL_RD, d);
        chk(d, 32'h0000_2EDF, "interval after reset");
        read_reg(CMD_REMAINING_RD, d);
        chk(d, 32'h0000_0000, "remaining after reset");
    endtask : test_defaults
    task automatic test_program();
        logic [31:0] d;
        write_reg(CMD_INTERVAL_WR, 32'h8005_0014);
        read_reg(CMD_INTERVAL_RD, d);
        chk(d, 32'h8005_0014, "interval readback");
        @(posedge core_clk_in);
        #1;
        chk({31'h0000_0000, rvalid_out}, 32'h0000_0000, "read answer lasts one cycle");
        chk(rdata_out, 32'h0000_0000, "read data cleared");
        write_reg(8'h8E, 32'hFFFF_FFFF);
        read_reg(CMD_INTERVAL_RD, d);
        chk(d, 32'h8005_0014, "interval after write to remaining code");
        read_reg(8'h0C, d);
        chk(d, 32'h0000_0000, "unknown read code");
    endtask : test_program
    task automatic test_frames();
        logic [31:0] d;
        @(posedge core_clk_in);
        bus_active_state_in <= 1'b1;
        wait_sof(gap);
        chk({16'h0000, frame_number_out}, 32'h0000_0001, "frame number on entry");
        wait_sof(gap);
        // 21 bit ticks at 8 or 9 clocks each average 175 clocks
        chk({31'h0000_0000, gap >= 174 && gap <= 176}, 32'h0000_0001, "frame length in clocks");
        chk({16'h0000, frame_number_out}, 32'h0000_0002, "frame number on reload");
        read_reg(CMD_REMAINING_RD, d);
        chk(d & 32'h7FFF_C000, 32'h0000_0000, "remaining reserved bits");
        chk({31'h0000_0000, d[31]}, 32'h0000_0001, "remaining toggle copied");
        chk({31'h0000_0000, d[13:0] <= 14'h0014}, 32'h0000_0001, "remaining within length");
        read_reg(CMD_FRAME_NUM_RD, d);
        chk(d, 32'h0000_0002, "frame number read");
    endtask : test_frames
    task automatic test_budget();
        wait_sof(gap);
        @(posedge core_clk_in);
        #1;
        chk({31'h0000_0000, packet_fits_out}, 32'h0000_0001, "budget loaded at frame start");
        chk({31'h0000_0000, sof_out}, 32'h0000_0000, "start of frame lasts one cycle");
        @(posedge core_clk_in);
        packet_bits_used_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        #1;
        chk({31'h0000_0000, packet_fits_out}, 32'h0000_0001, "budget one bit left");
        @(posedge core_clk_in);
        packet_bits_used_in <= 1'b0;
        #1;
        chk({31'h0000_0000, packet_fits_out}, 32'h0000_0000, "budget used up");
    endtask : test_budget
    // Retune at a frame start: old length ends its frame, new one rules the next
    task automatic test_retune();
        logic [31:0] d;
        wait_sof(gap);
        write_reg(CMD_INTERVAL_WR, 32'h0005_000A);
        wait_sof(gap);
        chk({31'h0000_0000, gap >= 172 && gap <= 174}, 32'h0000_0001, "old length kept to frame end");
        wait_sof(gap);
        chk({31'h0000_0000, gap >= 91 && gap <= 93}, 32'h0000_0001, "retuned frame length");
        read_reg(CMD_REMAINING_RD, d);
        chk({31'h0000_0000, d[31]}, 32'h0000_0000, "remaining toggle follows write");
    endtask : test_retune
    task automatic test_soft_reset();
        logic [31:0] d;
        logic [31:0] saved;
        read_reg(CMD_INTERVAL_RD, saved);
        chk(saved, 32'h0005_000A, "interval before soft reset");
        @(posedge core_clk_in);
        bus_active_state_in <= 1'b0;
        soft_reset_in <= 1'b1;
        cmd_valid_in <= 1'b1;
        cmd_code_in <= CMD_INTERVAL_WR;
        cmd_wdata_in <= 32'h0000_0100;
        @(posedge core_clk_in);
        soft_reset_in <= 1'b0;
        cmd_valid_in <= 1'b0;
        read_reg(CMD_INTERVAL_RD, d);
        chk(d, 32'h0000_2EDF, "interval after soft reset");
        chk({16'h0000, frame_number_out}, 32'h0000_0000, "frame number after soft reset");
        write_reg(CMD_INTERVAL_WR, 32'h8005_000A);
        read_reg(CMD_INTERVAL_RD, d);
        chk(d, 32'h8005_000A, "restored interval");
    endtask : test_soft_reset
    initial begin
        repeat (12) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        test_defaults();
        test_program();
        test_frames();
        test_budget();
        test_retune();
        test_soft_reset();
        end_sim();
    end
endmodule : tb
